// ===== verilog/sram_port.sv
// pipelined synchronous burst memory: pin-level control, burst, byte writes
// assumes all pin inputs are synchronous to clk; the two-way pins are
// resolved outside from the active-low output enables
`timescale 1ns/1ps
`default_nettype none
module sram_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clock_qualifier_n,
  input wire logic select_low_first,
  input wire logic select_high,
  input wire logic select_low_second,
  input wire logic write_n,
  input wire logic advance_or_load,
  input wire logic [sram_port_pkg::LANES-1:0] byte_lane_write_n,
  input wire logic [sram_port_pkg::ADDR_W-1:0] addr,
  input wire logic burst_order,
  input wire logic output_enable_n,
  input wire logic [sram_port_pkg::DATA_W-1:0] data_in,
  output logic [sram_port_pkg::DATA_W-1:0] data_out,
  output logic [sram_port_pkg::DATA_W-1:0] data_oe_n,
  input wire logic [sram_port_pkg::LANES-1:0] parity_pins_in,
  output logic [sram_port_pkg::LANES-1:0] parity_pins_out,
  output logic [sram_port_pkg::LANES-1:0] parity_pins_oe_n
);
  localparam int AW = sram_port_pkg::ADDR_W;
  localparam int LN = sram_port_pkg::LANES;
  localparam int DW = sram_port_pkg::DATA_W;
  localparam int WW = sram_port_pkg::WORD_W;
  localparam int EW = sram_port_pkg::ENTRY_W;

  // merge lane-selected bytes and parity of a write into a stored word
  function automatic logic [WW-1:0] merge(input logic [WW-1:0] word,
                                          input logic [DW-1:0] wdata,
                                          input logic [LN-1:0] wpar,
                                          input logic [LN-1:0] lanes_n);
    logic [WW-1:0] res;
    res = word;
    for (int i = 0; i < LN; i++) begin
      if (!lanes_n[i]) begin
        res[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] =
          wdata[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
        res[DW+i] = wpar[i];
      end
    end
    return res;
  endfunction

  logic [WW-1:0] mem_q [sram_port_pkg::DEPTH];
  logic [WW-1:0] mem_d [sram_port_pkg::DEPTH];
  logic active_q, active_d;
  logic burst_write_q, burst_write_d;
  logic [sram_port_pkg::UPPER_W-1:0] upper_q, upper_d;
  logic a_valid_q, a_valid_d;
  logic a_write_q, a_write_d;
  logic [AW-1:0] a_addr_q, a_addr_d;
  logic [LN-1:0] a_lanes_q, a_lanes_d;
  logic b_read_q, b_read_d;
  logic b_write_q, b_write_d;
  logic [AW-1:0] b_addr_q, b_addr_d;
  logic [LN-1:0] b_lanes_q, b_lanes_d;
  logic [WW-1:0] out_word_q, out_word_d;
  logic order_q, order_d;
  logic strap_taken_q, strap_taken_d;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [EW-1:0] buf_out_data;
  logic [EW-1:0] buf_in_data;
  logic qual;
  logic sel;
  logic drain;
  logic drive;
  logic [sram_port_pkg::OFFSET_W-1:0] offset_next;
  logic [WW-1:0] read_word;
  logic [AW-1:0] head_addr;
  logic [LN-1:0] head_lanes;

  // a full buffer holds every stage, the same way a high qualifier does
  assign qual = !clock_qualifier_n && buf_in_ready;
  assign sel = !select_low_first && select_high && !select_low_second;
  assign drain = !clock_qualifier_n;

  burst_counter u_burst (
    .clk(clk),
    .rst_n(rst_n),
    .load(qual && !advance_or_load),
    .step(qual && advance_or_load),
    .load_offset(addr[sram_port_pkg::OFFSET_W-1:0]),
    .interleaved(order_q == sram_port_pkg::ORDER_INTERLEAVED),
    .offset_next(offset_next)
  );

  // write words wait here until the array port takes them
  assign buf_in_data = {b_addr_q, b_lanes_q, data_in, parity_pins_in};
  two_entry_buffer #(
    .WIDTH(EW)
  ) u_wbuf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(qual && b_write_q),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(drain),
    .out_data(buf_out_data)
  );
  assign head_addr = buf_out_data[sram_port_pkg::ENTRY_ADDR_LSB +: AW];
  assign head_lanes = buf_out_data[sram_port_pkg::ENTRY_LANE_LSB +: LN];

  // read path forwards the pending buffer head and the write on the pins,
  // so a read right behind a write never sees stale data
  always_comb begin
    read_word = mem_q[a_addr_q];
    if (buf_out_valid && head_addr == a_addr_q) begin
      read_word = merge(read_word, buf_out_data[sram_port_pkg::ENTRY_DATA_LSB +: DW],
                        buf_out_data[sram_port_pkg::ENTRY_PAR_LSB +: LN], head_lanes);
    end
    if (b_write_q && b_addr_q == a_addr_q) begin
      read_word = merge(read_word, data_in, parity_pins_in, b_lanes_q);
    end
  end

  // array commit from the buffer head
  always_comb begin
    for (int j = 0; j < sram_port_pkg::DEPTH; j++) begin
      mem_d[j] = mem_q[j];
    end
    if (buf_out_valid && drain) begin
      mem_d[head_addr] = merge(mem_q[head_addr],
                               buf_out_data[sram_port_pkg::ENTRY_DATA_LSB +: DW],
                               buf_out_data[sram_port_pkg::ENTRY_PAR_LSB +: LN],
                               head_lanes);
    end
  end

  // strap is taken once after reset release; interleaved until then
  always_comb begin
    order_d = order_q;
    strap_taken_d = 1'b1;
    if (!strap_taken_q) begin
      order_d = burst_order;
    end
  end

  // address/control stage then data stage; nothing moves on an unqualified edge
  always_comb begin
    active_d = active_q;
    burst_write_d = burst_write_q;
    upper_d = upper_q;
    a_valid_d = a_valid_q;
    a_write_d = a_write_q;
    a_addr_d = a_addr_q;
    a_lanes_d = a_lanes_q;
    b_read_d = b_read_q;
    b_write_d = b_write_q;
    b_addr_d = b_addr_q;
    b_lanes_d = b_lanes_q;
    out_word_d = out_word_q;
    if (qual) begin
      a_valid_d = 1'b0;
      a_write_d = 1'b0;
      if (!advance_or_load) begin
        active_d = sel;
        if (sel) begin
          burst_write_d = !write_n;
          upper_d = addr[AW-1:sram_port_pkg::OFFSET_W];
          a_valid_d = 1'b1;
          a_write_d = !write_n;
        end
      end else if (active_q) begin
        a_valid_d = 1'b1;
        a_write_d = burst_write_q;
      end
      a_addr_d = {upper_d, offset_next};
      a_lanes_d = byte_lane_write_n;
      b_read_d = a_valid_q && !a_write_q;
      b_write_d = a_valid_q && a_write_q;
      b_addr_d = a_addr_q;
      b_lanes_d = a_lanes_q;
      if (a_valid_q && !a_write_q) begin
        out_word_d = read_word;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int j = 0; j < sram_port_pkg::DEPTH; j++) begin
        mem_q[j] <= sram_port_pkg::WORD_RESET;
      end
      active_q <= 1'b0;
      burst_write_q <= 1'b0;
      upper_q <= '0;
      a_valid_q <= 1'b0;
      a_write_q <= 1'b0;
      a_addr_q <= '0;
      a_lanes_q <= '1;
      b_read_q <= 1'b0;
      b_write_q <= 1'b0;
      b_addr_q <= '0;
      b_lanes_q <= '1;
      out_word_q <= sram_port_pkg::WORD_RESET;
      order_q <= sram_port_pkg::ORDER_RESET;
      strap_taken_q <= 1'b0;
    end else begin
      for (int j = 0; j < sram_port_pkg::DEPTH; j++) begin
        mem_q[j] <= mem_d[j];
      end
      active_q <= active_d;
      burst_write_q <= burst_write_d;
      upper_q <= upper_d;
      a_valid_q <= a_valid_d;
      a_write_q <= a_write_d;
      a_addr_q <= a_addr_d;
      a_lanes_q <= a_lanes_d;
      b_read_q <= b_read_d;
      b_write_q <= b_write_d;
      b_addr_q <= b_addr_d;
      b_lanes_q <= b_lanes_d;
      out_word_q <= out_word_d;
      order_q <= order_d;
      strap_taken_q <= strap_taken_d;
    end
  end

  // drivers on only in a read data phase, one qualified edge after the read select;
  // write phases and deselected cycles never set b_read_q
  assign drive = b_read_q && !output_enable_n;
  assign data_out = out_word_q[DW-1:0];
  assign parity_pins_out = out_word_q[WW-1:DW];
  assign data_oe_n = {DW{!drive}};
  assign parity_pins_oe_n = {LN{!drive}};

  property p_hold_unqualified;
    @(posedge clk) disable iff (!rst_n)
      clock_qualifier_n |=> $stable(a_addr_q) && $stable(b_read_q) && $stable(out_word_q)
                            && $stable(active_q);
  endproperty
  a_hold_unqualified: assert property (p_hold_unqualified) else $error("state moved while unqualified");

  property p_stretch_keeps_select;
    @(posedge clk) disable iff (!rst_n)
      active_q && clock_qualifier_n |=> active_q && $stable(burst_write_q) && $stable(upper_q);
  endproperty
  a_stretch_keeps_select: assert property (p_stretch_keeps_select) else $error("stretch deselected");

  property p_select_decode;
    @(posedge clk) disable iff (!rst_n)
      qual && !advance_or_load |=> a_valid_q == $past(sel) && active_q == $past(sel);
  endproperty
  a_select_decode: assert property (p_select_decode) else $error("select decode wrong");

  property p_load_address;
    @(posedge clk) disable iff (!rst_n)
      qual && !advance_or_load && sel |=> a_addr_q == $past(addr);
  endproperty
  a_load_address: assert property (p_load_address) else $error("address not loaded");

  property p_linear_step;
    @(posedge clk) disable iff (!rst_n)
      qual && advance_or_load && order_q == sram_port_pkg::ORDER_LINEAR && strap_taken_q
      |=> a_addr_q[1:0] == 2'($past(a_addr_q[1:0]) + 2'h1) && $stable(a_addr_q[AW-1:2]);
  endproperty
  a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

  property p_burst_type;
    @(posedge clk) disable iff (!rst_n)
      qual && advance_or_load && active_q |=> a_valid_q && a_write_q == $past(burst_write_q);
  endproperty
  a_burst_type: assert property (p_burst_type) else $error("burst type changed");

  property p_read_latency;
    @(posedge clk) disable iff (!rst_n)
      qual && a_valid_q && !a_write_q |=> b_read_q && out_word_q == $past(read_word);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data late or wrong");

  property p_drive_cause;
    @(posedge clk) disable iff (!rst_n)
      (b_read_q && !output_enable_n) == !data_oe_n[0] && data_oe_n == {DW{data_oe_n[0]}}
      && parity_pins_oe_n == {LN{data_oe_n[0]}} && !(b_read_q && b_write_q);
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("pins driven without read");

  property p_write_float;
    @(posedge clk) disable iff (!rst_n)
      b_write_q |-> &data_oe_n && &parity_pins_oe_n;
  endproperty
  a_write_float: assert property (p_write_float) else $error("pins driven in float case");

  // deselect is pipelined: pins float once the next qualified edge has passed
  property p_deselect_float;
    @(posedge clk) disable iff (!rst_n)
      qual && !advance_or_load && !sel ##1 qual |=> &data_oe_n && &parity_pins_oe_n;
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("deselect drove pins");

  property p_write_capture;
    @(posedge clk) disable iff (!rst_n)
      qual && b_write_q |=> buf_out_valid;
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("write data not captured");

  c_read: cover property (@(posedge clk) disable iff (!rst_n) qual && a_valid_q && !a_write_q);
  c_write: cover property (@(posedge clk) disable iff (!rst_n) qual && b_write_q);
  c_burst4: cover property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_or_load && active_q) [*3]);
  c_turn: cover property (@(posedge clk) disable iff (!rst_n)
    b_write_q && qual ##1 b_read_q);
endmodule
`default_nettype wire

// ===== verilog/sram_port_pkg.sv
// constants shared by the pipelined synchronous memory port and its helpers
// assumes a single clock and a four-lane word with one parity bit per lane
package sram_port_pkg;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = LANES * LANE_W;
  localparam int WORD_W = DATA_W + LANES;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int OFFSET_W = 2;
  localparam int UPPER_W = ADDR_W - OFFSET_W;
  localparam int ENTRY_W = ADDR_W + LANES + DATA_W + LANES;
  // field positions inside a buffered write entry
  localparam int ENTRY_PAR_LSB = 0;
  localparam int ENTRY_DATA_LSB = LANES;
  localparam int ENTRY_LANE_LSB = LANES + DATA_W;
  localparam int ENTRY_ADDR_LSB = LANES + DATA_W + LANES;
  // burst order strap encoding and its value before the strap is taken
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_RESET = ORDER_INTERLEAVED;
  localparam logic [OFFSET_W-1:0] BEAT_RESET = 2'h0;
  localparam logic [OFFSET_W-1:0] BEAT_STEP = 2'h1;
  localparam logic [WORD_W-1:0] WORD_RESET = 36'h0;
  // buffer state codes
  typedef enum logic [2:0] {
    BUF_EMPTY = 3'b001,
    BUF_ONE = 3'b010,
    BUF_TWO = 3'b100
  } buf_state_e;
endpackage

// ===== verilog/burst_counter.sv
// two-bit burst offset generator with linear or interleaved order
// assumes load and step are already qualified by the clock qualifier
`timescale 1ns/1ps
`default_nettype none
module burst_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic [sram_port_pkg::OFFSET_W-1:0] load_offset,
  input wire logic interleaved,
  output logic [sram_port_pkg::OFFSET_W-1:0] offset_next
);
  logic [sram_port_pkg::OFFSET_W-1:0] base_q, base_d;
  logic [sram_port_pkg::OFFSET_W-1:0] beat_q, beat_d;

  // next base and beat; the offset follows from the beat count
  always_comb begin
    base_d = base_q;
    beat_d = beat_q;
    if (load) begin
      base_d = load_offset;
      beat_d = sram_port_pkg::BEAT_RESET;
    end else if (step) begin
      beat_d = beat_q + sram_port_pkg::BEAT_STEP; // wraps after four beats
    end
    if (interleaved) begin
      offset_next = base_d ^ beat_d;
    end else begin
      offset_next = base_d + beat_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_q <= sram_port_pkg::BEAT_RESET;
      beat_q <= sram_port_pkg::BEAT_RESET;
    end else begin
      base_q <= base_d;
      beat_q <= beat_d;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/two_entry_buffer.sv
// two-entry valid/ready buffer for committed write words
// assumes the drain side may stall for any number of cycles
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  sram_port_pkg::buf_state_e state_q, state_d;
  logic [WIDTH-1:0] slot_q [2];
  logic [WIDTH-1:0] slot_d [2];
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic push;
  logic pop;

  assign in_ready = (state_q != sram_port_pkg::BUF_TWO);
  assign out_valid = (state_q != sram_port_pkg::BUF_EMPTY);
  assign out_data = slot_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // occupancy and pointer update
  always_comb begin
    slot_d[0] = slot_q[0];
    slot_d[1] = slot_q[1];
    rd_d = rd_q ^ pop;
    wr_d = wr_q ^ push;
    if (push) begin
      slot_d[wr_q] = in_data;
    end
    case (state_q)
      sram_port_pkg::BUF_EMPTY: state_d = push ? sram_port_pkg::BUF_ONE : sram_port_pkg::BUF_EMPTY;
      sram_port_pkg::BUF_ONE: begin
        if (push && !pop) begin
          state_d = sram_port_pkg::BUF_TWO;
        end else if (pop && !push) begin
          state_d = sram_port_pkg::BUF_EMPTY;
        end else begin
          state_d = sram_port_pkg::BUF_ONE;
        end
      end
      sram_port_pkg::BUF_TWO: state_d = pop ? sram_port_pkg::BUF_ONE : sram_port_pkg::BUF_TWO;
      default: state_d = sram_port_pkg::BUF_EMPTY;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= sram_port_pkg::BUF_EMPTY;
      slot_q[0] <= '0;
      slot_q[1] <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      slot_q[0] <= slot_d[0];
      slot_q[1] <= slot_d[1];
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end
endmodule
`default_nettype wire

// ===== tb/host_model.sv
// host memory controller model that drives the synchronous port's pins
// assumes the bench calls its tasks a short fixed delay after a rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output logic clock_qualifier_n,
  output logic select_low_first,
  output logic select_high,
  output logic select_low_second,
  output logic write_n,
  output logic advance_or_load,
  output logic [sram_port_pkg::LANES-1:0] byte_lane_write_n,
  output logic [sram_port_pkg::ADDR_W-1:0] addr,
  output logic burst_order,
  output logic output_enable_n,
  output logic drive_en,
  output logic [sram_port_pkg::DATA_W-1:0] wdata,
  output logic [sram_port_pkg::LANES-1:0] wpar
);
  logic desel_q;

  // idle bus: qualifier high, deselected, no data driven
  initial begin
    clock_qualifier_n = 1'b1;
    {select_low_first, select_high, select_low_second} = 3'h6;
    write_n = 1'b1;
    advance_or_load = 1'b0;
    byte_lane_write_n = 4'hf;
    addr = 4'h0;
    burst_order = 1'b1;
    output_enable_n = 1'b1;
    drive_en = 1'b0;
    wdata = 32'h0;
    wpar = 4'h0;
    desel_q = 1'b1;
  end

  // strap only moves while the port sits in reset
  task automatic set_order(input logic order);
    burst_order = order;
  endtask

  // one request, held until the next rising edge
  task automatic put(input logic q, input logic [2:0] sel, input logic wr, input logic adv,
                     input logic [3:0] ln, input logic [3:0] a, input logic oe);
    clock_qualifier_n = q;
    {select_low_first, select_high, select_low_second} = sel;
    write_n = wr;
    // a step straight after a deselect would continue a dead burst
    advance_or_load = adv & ~desel_q;
    byte_lane_write_n = ln;
    addr = a;
    output_enable_n = oe;
    if (!q && !advance_or_load) begin
      desel_q = (sel != 3'h2);
    end
  endtask

  // write data phase: drive or release the data pins
  task automatic put_data(input logic en, input logic [31:0] d, input logic [3:0] p);
    drive_en = en;
    wdata = d;
    wpar = p;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the pipelined synchronous memory port
// assumes the host model drives every pin input; bench resolves the two-way pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic vld; logic rd; logic [3:0] a; logic [3:0] ln;} op_s;
  logic clk;
  logic rst_n;
  logic qn, s1, s2, s3, wn, adv, order, oe_pin, hdrv, interleave, qual_last, bact, brd;
  logic [3:0] ln, a, hpar, pout, poe_n, base;
  logic [31:0] hdata, dout, doe_n;
  logic [31:0] bus_last = 32'h0;
  logic [3:0] plast = 4'h0;
  logic [1:0] beat;
  logic [31:0] mem_d [16];
  logic [3:0] mem_p [16];
  op_s drv, cur, prev;
  int errors, total_checks;
  // released pins show a changing pattern, never the last value
  wire logic [31:0] bus = hdrv ? hdata : (doe_n[0] ? ~bus_last : dout);
  wire logic [3:0] pbus = hdrv ? hpar : (poe_n[0] ? ~plast : pout);

  always @(posedge clk) begin
    bus_last <= bus;
    plast <= pbus;
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  host_model i_host (.clock_qualifier_n(qn), .select_low_first(s1), .select_high(s2),
    .select_low_second(s3), .write_n(wn), .advance_or_load(adv), .byte_lane_write_n(ln),
    .addr(a), .burst_order(order), .output_enable_n(oe_pin), .drive_en(hdrv),
    .wdata(hdata), .wpar(hpar));

  sram_port i_dut (.clk(clk), .rst_n(rst_n), .clock_qualifier_n(qn), .select_low_first(s1),
    .select_high(s2), .select_low_second(s3), .write_n(wn), .advance_or_load(adv),
    .byte_lane_write_n(ln), .addr(a), .burst_order(order), .output_enable_n(oe_pin),
    .data_in(bus), .data_out(dout), .data_oe_n(doe_n), .parity_pins_in(pbus),
    .parity_pins_out(pout), .parity_pins_oe_n(poe_n));

  // burst address: offset bits only, linear adds, interleaved xors
  function automatic logic [3:0] beat_addr(input logic [3:0] b, input logic [1:0] n,
                                           input logic il);
    beat_addr = {b[3:2], il ? (b[1:0] ^ n) : (b[1:0] + n)};
  endfunction

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // kind 0 deselect, 1 read, 2 write, 3 burst step; q high stalls the edge
  task automatic op(input logic q, input int kind, input logic [3:0] ad, input logic [3:0] lanes);
    logic [31:0] d;
    logic [3:0] p;
    logic [2:0] sel;
    @(posedge clk);
    #2;
    if (!qual_last) begin
      prev = cur;
      cur = drv;
      d = $urandom;
      p = 4'($urandom);
      i_host.put_data(prev.vld && !prev.rd, d, p);
      // model memory takes the write as its data phase starts
      if (prev.vld && !prev.rd) begin
        for (int i = 0; i < 4; i++) begin
          if (!prev.ln[i]) begin
            mem_d[prev.a][8*i +: 8] = d[8*i +: 8];
            mem_p[prev.a][i] = p[i];
          end
        end
      end
    end
    sel = 3'h2;
    if (kind == 3 && !(bact && beat < 3)) kind = 1;
    if (q) begin
      sel = 3'($urandom);
    end else if (kind == 3) begin
      beat++;
      sel = 3'($urandom);
      drv = '{1'b1, brd, beat_addr(base, beat, interleave), lanes};
    end else if (kind == 0) begin
      sel = 3'($urandom);
      if (sel == 3'h2) sel = 3'h6;
      bact = 1'b0;
      drv = '0;
    end else begin
      base = ad;
      beat = 2'h0;
      bact = 1'b1;
      brd = (kind == 1);
      drv = '{1'b1, brd, ad, lanes};
    end
    i_host.put(q, sel, (kind == 3) ? 1'($urandom) : (kind != 2), kind == 3, lanes, ad,
               $urandom % 4 == 0);
    qual_last = q;
    #1;
    if (prev.vld && prev.rd) begin
      chk("read word", {mem_p[prev.a], mem_d[prev.a]}, {pout, dout});
    end
    chk("output enables", {36{~(prev.vld && prev.rd && !oe_pin)}}, {poe_n, doe_n});
  endtask

  task automatic do_reset(input logic il);
    rst_n = 1'b0;
    interleave = il;
    i_host.set_order(il);
    for (int i = 0; i < 16; i++) begin
      mem_d[i] = 32'h0;
      mem_p[i] = 4'h0;
    end
    drv = '0;
    cur = '0;
    prev = '0;
    qual_last = 1'b1;
    bact = 1'b0;
    // output enable low: pins must still float while deselected
    i_host.put(1'b1, 3'h6, 1'b1, 1'b0, 4'hf, 4'h0, 1'b0);
    // a write phase cut by reset must not leave the host on the pins
    i_host.put_data(1'b0, 32'h0, 4'h0);
    repeat (20) @(posedge clk);
    #2;
    chk("reset enables", 36'hfffffffff, {poe_n, doe_n});
    chk("reset data", 36'h0, {pout, dout});
    rst_n = 1'b1;
  endtask

  // hand-picked awkward sequences
  task automatic corners();
    op(1'b0, 2, 4'h5, 4'h0);
    op(1'b0, 1, 4'h5, 4'h0);
    op(1'b0, 2, 4'h5, 4'ha);
    op(1'b0, 1, 4'h5, 4'h0);
    op(1'b1, 2, 4'h3, 4'h0);
    op(1'b1, 1, 4'h7, 4'h0);
    op(1'b0, 1, 4'h5, 4'h0);
    op(1'b0, 0, 4'h0, 4'h0);
    op(1'b0, 1, 4'h5, 4'h0);
    op(1'b0, 2, 4'h9, 4'h3);
    repeat (3) op(1'b0, 3, 4'h0, 4'h0);
    op(1'b0, 1, 4'h9, 4'h0);
    repeat (3) op(1'b0, 3, 4'h0, 4'h0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // both strap settings, each after a fresh reset
  initial begin
    errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    void'($urandom(1077));
    for (int m = 1; m >= 0; m--) begin
      do_reset(m[0]);
      corners();
      $display("test corners order %0d done", m);
      repeat (300) op($urandom % 5 == 0, $urandom % 4, 4'($urandom), 4'($urandom));
      $display("test random order %0d done", m);
    end
    repeat (3) op(1'b0, 0, 4'h0, 4'hf);
    results();
  end

  // run needs about 700 cycles; a hang past 3000 is a failure
  initial begin
    #(3000 * 50);
    errors++;
    results();
  end
endmodule
`default_nettype wire
